// ==== core/wrc_pkg.sv ====
// Shared types and constants for the watchdog and reset control block.
// Assumes a single 25 MHz system clock and static fuse levels.
// Function
// - Supply-low indication asserts internal reset at once, without delay.
// - Supply-low release starts delay counter; reset held until its time-out.
// - Low external reset pin resets asynchronously, even with no clock.
// - After reset pin rises, delay counter time-out runs before release.
// - Enabled brown-out asserts reset; release follows the delay time-out.
// - Brown-out counts only when low-supply persists beyond a minimum time.
// - Watchdog expiry makes a reset pulse exactly one clock cycle long.
// - Delay counter starts on trailing edge of the watchdog pulse.
// - Reference enable follows brown-out fuse, bandgap select or converter enable.
// - Watchdog counter advances on the separate 1 MHz oscillator.
// - Watchdog counter cleared by restart, when disabled, and on chip reset.
// - Three-bit prescale select picks one of eight watchdog periods.
// - Enabled watchdog reaching its period without restart resets the device.
// - Safety level from fuses: always-on gives 2, compat gives 0, else 1.
// - Writing one to the enable bit always enables, no sequence needed.
// - Level 0 takes prescale writes anytime; disabling still needs the sequence.
// - Level 1 second write within four cycles sets enable and prescale.
// - Level 2 keeps the watchdog enabled and reads enable as one.
// - Level 2 second write updates prescale only; enable value ignored.
// - Change-enable clears itself four clock cycles after being set.
// - Prescale 000 gives 16K oscillator cycles, doubling up to 2048K.
// - Sticky watchdog reset flag; cleared by supply reset or software zero.
package wrc_pkg;

    typedef struct packed {
        logic chg_en;
        logic en;
        logic [2:0] presc;
    } wrc_wdt_ctrl_t;

    typedef struct packed {
        logic always_on;
        logic compat;
        logic lsd_en;
    } wrc_fuse_t;

    typedef enum logic [2:0] {
        RS_RUN = 3'h1,
        RS_HOLD = 3'h2,
        RS_DELAY = 3'h4
    } wrc_rst_state_t;

    localparam int CLK_NS = 40;
    localparam int WD_OSC_HZ = 1000000;
    localparam int LSD_MIN_NS = 2000;
    localparam int LSD_MIN_CYC = (LSD_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [7:0] LSD_MIN_CNT = 8'(LSD_MIN_CYC);
    localparam int WIN_CYC = 4;
    localparam logic [2:0] WIN_LOAD = 3'(WIN_CYC - 1);
    localparam int WD_BASE_DEF = 16384;
    localparam int TOUT_W = 16;
    localparam int WD_CNT_W = 22;
    localparam logic [1:0] LVL_0 = 2'h0;
    localparam logic [1:0] LVL_1 = 2'h1;
    localparam logic [1:0] LVL_2 = 2'h2;
    localparam logic [2:0] PRESC_RST = 3'h0;

endpackage

// ==== core/wrc_top.sv ====
// Reset sequencer, brown-out filter and watchdog with timed configuration writes.
// Assumes analog indications, the reset pin, the watchdog oscillator and fuses
// arrive asynchronously, while register strobes come from the clk domain.
`timescale 1ns/1ns
`default_nettype none

module wrc_top
    import wrc_pkg::*;
#(
    parameter int WD_BASE_CYC = WD_BASE_DEF
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic supply_low,
    input wire logic reset_pin_n,
    input wire logic low_supply_detect,
    input wire logic wd_osc,
    input wire wrc_fuse_t fuses,
    input wire logic [TOUT_W-1:0] reset_delay_timeout,
    input wire logic wd_restart,
    input wire logic wdt_wr,
    input wire wrc_wdt_ctrl_t wdt_wdata,
    output wrc_wdt_ctrl_t wdt_rdata,
    input wire logic flag_wr,
    input wire logic flag_wdata,
    output logic wd_reset_flag,
    input wire logic comparator_bandgap_select,
    input wire logic converter_enable,
    output logic vref_enable,
    output logic core_reset,
    output logic [1:0] safety_level
);

    logic [6:0] sync1_q;
    logic [6:0] sync2_q;
    logic supply_s;
    logic pin_low_s;
    logic lsd_s;
    logic osc_s;
    wrc_fuse_t fuse_s;
    logic osc_d_q;
    logic osc_tick;
    logic [7:0] lsd_cnt_q;
    logic lsd_valid_q;
    wrc_rst_state_t st_q;
    logic [TOUT_W-1:0] dly_cnt_q;
    logic [TOUT_W-1:0] dly_last;
    logic src_active;
    logic chip_rst;
    logic [1:0] level;
    logic en_q;
    logic ce_q;
    logic [2:0] ce_cnt_q;
    logic [2:0] presc_q;
    logic en_eff;
    logic win_open;
    logic win_second;
    logic [WD_CNT_W-1:0] wd_cnt_q;
    logic [WD_CNT_W-1:0] wd_last;
    logic wd_expire;
    logic wd_pulse_q;
    logic flag_q;
    logic vref_q;

    // Two-flop synchronisers for every asynchronous input.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1_q <= 7'h00;
            sync2_q <= 7'h00;
        end else begin
            sync1_q <= {supply_low, ~reset_pin_n, low_supply_detect, wd_osc, fuses};
            sync2_q <= sync1_q;
        end
    end

    assign supply_s = sync2_q[6];
    assign pin_low_s = sync2_q[5];
    assign lsd_s = sync2_q[4];
    assign osc_s = sync2_q[3];
    assign fuse_s = sync2_q[2:0];

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            osc_d_q <= 1'b0;
        end else begin
            osc_d_q <= osc_s;
        end
    end

    assign osc_tick = osc_s & ~osc_d_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lsd_cnt_q <= 8'h00;
            lsd_valid_q <= 1'b0;
        end else if (!(lsd_s && fuse_s.lsd_en)) begin
            lsd_cnt_q <= 8'h00;
            lsd_valid_q <= 1'b0;
        end else if (lsd_cnt_q >= LSD_MIN_CNT) begin
            lsd_valid_q <= 1'b1;
        end else begin
            lsd_cnt_q <= lsd_cnt_q + 8'h01;
        end
    end

    assign src_active = supply_s | pin_low_s | lsd_valid_q | wd_pulse_q;

    // time-out taken from the configuration input
    assign dly_last = (reset_delay_timeout == '0) ? '0 : reset_delay_timeout - 1'b1;

    // delay counter stretches reset after every source clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st_q <= RS_HOLD;
            dly_cnt_q <= '0;
        end else begin
            case (st_q)
                RS_RUN: begin
                    if (src_active) begin
                        st_q <= RS_HOLD;
                    end
                end
                RS_HOLD: begin
                    dly_cnt_q <= '0;
                    if (!src_active) begin
                        st_q <= RS_DELAY;
                    end
                end
                RS_DELAY: begin
                    if (src_active) begin
                        st_q <= RS_HOLD;
                    end else if (dly_cnt_q >= dly_last) begin
                        st_q <= RS_RUN;
                    end else begin
                        dly_cnt_q <= dly_cnt_q + 1'b1;
                    end
                end
                default: begin
                    st_q <= RS_HOLD;
                end
            endcase
        end
    end

    assign chip_rst = (st_q != RS_RUN);

    // raw supply and pin levels reach reset with no clock involved
    assign core_reset = rst | supply_low | ~reset_pin_n | lsd_valid_q | wd_pulse_q | chip_rst;

    assign level = fuse_s.always_on ? LVL_2 : (fuse_s.compat ? LVL_0 : LVL_1);
    assign safety_level = level;

    assign en_eff = en_q | (level == LVL_2);

    assign win_open = wdt_wr & wdt_wdata.chg_en & wdt_wdata.en;
    assign win_second = wdt_wr & ~wdt_wdata.chg_en & ce_q;

    // change window closes four cycles after opening
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ce_q <= 1'b0;
            ce_cnt_q <= 3'h0;
        end else if (supply_s) begin
            ce_q <= 1'b0;
            ce_cnt_q <= 3'h0;
        end else if (win_open) begin
            ce_q <= 1'b1;
            ce_cnt_q <= WIN_LOAD;
        end else if (win_second) begin
            ce_q <= 1'b0;
        end else if (ce_q) begin
            if (ce_cnt_q == 3'h0) begin
                ce_q <= 1'b0;
            end else begin
                ce_cnt_q <= ce_cnt_q - 3'h1;
            end
        end
    end

    // enable written freely, cleared only inside window
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_q <= 1'b0;
        end else if (supply_s) begin
            en_q <= 1'b0;
        end else if (wdt_wr && wdt_wdata.en) begin
            en_q <= 1'b1;
        end else if (win_second && level != LVL_2) begin
            en_q <= 1'b0;
        end
    end

    // prescale open at level 0, windowed otherwise
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            presc_q <= PRESC_RST;
        end else if (supply_s) begin
            presc_q <= PRESC_RST;
        end else if (wdt_wr && (level == LVL_0 || win_second)) begin
            presc_q <= wdt_wdata.presc;
        end
    end

    assign wdt_rdata = '{chg_en: ce_q, en: en_eff, presc: presc_q};

    // period doubles per prescale step from the base count
    assign wd_last = (WD_CNT_W'(WD_BASE_CYC) << presc_q) - 1'b1;

    assign wd_expire = en_eff & osc_tick & (wd_cnt_q >= wd_last) & ~chip_rst;

    // counter clears on restart, disable and chip reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_cnt_q <= '0;
        end else if (chip_rst || !en_eff || wd_restart || wd_expire) begin
            wd_cnt_q <= '0;
        end else if (osc_tick) begin
            wd_cnt_q <= wd_cnt_q + 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wd_pulse_q <= 1'b0;
        end else begin
            wd_pulse_q <= wd_expire;
        end
    end

    // sticky flag, set beats software clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (supply_s) begin
            flag_q <= 1'b0;
        end else if (wd_pulse_q) begin
            flag_q <= 1'b1;
        end else if (flag_wr && !flag_wdata) begin
            flag_q <= 1'b0;
        end
    end

    assign wd_reset_flag = flag_q;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            vref_q <= 1'b0;
        end else begin
            vref_q <= fuse_s.lsd_en | comparator_bandgap_select | converter_enable;
        end
    end

    assign vref_enable = vref_q;

    default clocking cb @(posedge clk);
    endclocking

    default disable iff (rst);

    supply_reset_a: assert property (supply_low |-> core_reset)
        else $error("Supply low without reset.");

    pin_reset_a: assert property (!reset_pin_n |-> core_reset)
        else $error("Reset pin low without reset.");

    wd_pulse_one_a: assert property (wd_pulse_q |=> !wd_pulse_q)
        else $error("Watchdog pulse longer than one cycle.");

    pulse_hold_a: assert property ($fell(wd_pulse_q) |-> st_q == RS_HOLD ##1 core_reset)
        else $error("Reset released at watchdog pulse end.");

    delay_release_a: assert property ($rose(st_q == RS_RUN) |->
        $past(dly_cnt_q) >= $past(dly_last))
        else $error("Reset released before time-out.");

    delay_restart_a: assert property (st_q == RS_DELAY && src_active |=> st_q == RS_HOLD)
        else $error("Delay not restarted by a new source.");

    pin_hold_a: assert property (pin_low_s |=> chip_rst)
        else $error("Reset pin low did not hold the sequencer.");

    lsd_drop_a: assert property (!(lsd_s && fuse_s.lsd_en) |=> !lsd_valid_q)
        else $error("Brown-out valid without a low supply.");

    lsd_reset_a: assert property (lsd_valid_q |-> core_reset)
        else $error("Brown-out without reset.");

    window_open_a: assert property (win_open && !supply_s |=> ce_q)
        else $error("Change window did not open.");

    window_close_a: assert property ((win_open ##1 (!win_open) [*4]) |=> !ce_q)
        else $error("Change window stayed open too long.");

    level2_read_a: assert property (level == LVL_2 |-> wdt_rdata.en)
        else $error("Enable reads zero at level 2.");

    enable_write_a: assert property (wdt_wr && wdt_wdata.en && !supply_s
        |=> wdt_rdata.en)
        else $error("Enable write refused.");

    no_disable_a: assert property (wdt_wr && !wdt_wdata.en && !ce_q && en_q && !supply_s
        |=> en_q)
        else $error("Watchdog disabled outside window.");

    window_disable_a: assert property (win_second && !wdt_wdata.en && level != LVL_2
        && !supply_s |=> !en_q && presc_q == $past(wdt_wdata.presc))
        else $error("Windowed write not applied.");

    level0_presc_a: assert property (wdt_wr && level == LVL_0 && !supply_s
        |=> presc_q == $past(wdt_wdata.presc))
        else $error("Prescale write refused at level 0.");

    presc_locked_a: assert property (wdt_wr && level != LVL_0 && !ce_q && !supply_s
        |=> $stable(presc_q))
        else $error("Prescale changed outside window.");

    level2_presc_a: assert property (win_second && level == LVL_2 && !supply_s
        |=> wdt_rdata.en && presc_q == $past(wdt_wdata.presc))
        else $error("Level 2 windowed write not applied.");

    wd_clear_a: assert property (wd_restart || !en_eff || chip_rst |=> wd_cnt_q == '0)
        else $error("Watchdog counter not cleared.");

    expiry_pulse_a: assert property (wd_expire |=> wd_pulse_q)
        else $error("Expiry without reset pulse.");

    flag_set_a: assert property (wd_pulse_q && !supply_s |=> wd_reset_flag)
        else $error("Watchdog flag not set.");

    flag_clear_a: assert property (flag_wr && !flag_wdata && !wd_pulse_q
        |=> !wd_reset_flag)
        else $error("Watchdog flag not cleared.");

    flag_hold_a: assert property (wd_reset_flag && !supply_s
        && !(flag_wr && !flag_wdata) |=> wd_reset_flag)
        else $error("Watchdog flag lost.");

    vref_track_a: assert property (##1 vref_enable ==
        $past(fuse_s.lsd_en | comparator_bandgap_select | converter_enable))
        else $error("Reference enable mismatch.");

    wd_expiry_c: cover property (wd_pulse_q ##1 core_reset);
    window_disable_c: cover property (win_open ##[1:4] (win_second && !wdt_wdata.en));
    lsd_valid_c: cover property ($rose(lsd_valid_q));
    release_c: cover property ($rose(st_q == RS_RUN));
    level2_change_c: cover property (level == LVL_2 && win_second);

endmodule

`default_nettype wire

// ==== verification/wrc_tb.sv ====
// Self-checking bench for the watchdog and reset control block.
// Assumes the block carries its own assertions; inputs change at falling edges.
`timescale 1ns/1ns
`default_nettype none

module testbench;
    import wrc_pkg::*;
    localparam int BASE = 16;
    localparam int TOUT = 10;
    logic clk, rst, supply_low, reset_pin_n, low_supply_detect, wd_osc;
    logic wd_restart, wdt_wr, flag_wr, flag_wdata, bandgap, conv;
    logic wd_reset_flag, vref_enable, core_reset;
    logic [1:0] safety_level;
    wrc_fuse_t fuses;
    wrc_wdt_ctrl_t wdt_wdata, wdt_rdata;
    int n_mismatch, checks;
    logic [15:0] tout;

    wrc_top #(.WD_BASE_CYC(BASE)) dut_u (
        .clk(clk), .rst(rst), .supply_low(supply_low), .reset_pin_n(reset_pin_n),
        .low_supply_detect(low_supply_detect), .wd_osc(wd_osc), .fuses(fuses),
        .reset_delay_timeout(tout), .wd_restart(wd_restart), .wdt_wr(wdt_wr),
        .wdt_wdata(wdt_wdata), .wdt_rdata(wdt_rdata), .flag_wr(flag_wr),
        .flag_wdata(flag_wdata), .wd_reset_flag(wd_reset_flag),
        .comparator_bandgap_select(bandgap), .converter_enable(conv),
        .vref_enable(vref_enable), .core_reset(core_reset), .safety_level(safety_level)
    );

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // The watchdog oscillator runs free at 1 MHz, offset from the system clock.
    initial begin
        wd_osc = 1'b0;
        #7;
        forever #500 wd_osc = ~wd_osc;
    end

    task automatic close_out;
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic chk_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_val(input logic [4:0] got, input logic [4:0] exp);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_rng(input int got, input int lo, input int hi);
        checks++;
        if (got < lo || got > hi) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
        end
    endtask

    // Waits a bounded number of cycles for core_reset to reach a level.
    task automatic wait_lvl(input logic v, input int bound, output int n);
        n = 0;
        while (core_reset !== v) begin
            @(negedge clk);
            n++;
            if (n > bound) begin
                n_mismatch++;
                close_out();
            end
        end
    endtask

    task automatic wr(input logic c, input logic e, input logic [2:0] p);
        @(negedge clk);
        wdt_wr = 1'b1;
        wdt_wdata = '{chg_en: c, en: e, presc: p};
        @(negedge clk);
        wdt_wr = 1'b0;
    endtask

    task automatic do_reset(input wrc_fuse_t f);
        int n;
        @(negedge clk);
        fuses = f;
        rst = 1'b1;
        repeat (16) @(negedge clk);
        rst = 1'b0;
        wait_lvl(1'b0, 60, n);
    endtask

    task automatic s_supply;
        int n;
        @(negedge clk);
        supply_low = 1'b1;
        #1 chk_bit(core_reset, 1'b1);
        repeat (5) @(negedge clk);
        supply_low = 1'b0;
        wait_lvl(1'b0, 60, n);
        chk_rng(n, TOUT, TOUT + 6);
    endtask

    task automatic s_pin;
        int n;
        @(negedge clk);
        tout = 16'(2 * TOUT);
        reset_pin_n = 1'b0;
        #1 chk_bit(core_reset, 1'b1);
        repeat (5) @(negedge clk);
        reset_pin_n = 1'b1;
        wait_lvl(1'b0, 60, n);
        chk_rng(n, 2 * TOUT, 2 * TOUT + 6);
        tout = 16'(TOUT);
    endtask

    task automatic s_vref;
        for (int i = 0; i < 4; i++) begin
            @(negedge clk);
            bandgap = i[0];
            conv = i[1];
            repeat (2) @(negedge clk);
            chk_bit(vref_enable, i[0] | i[1]);
        end
        bandgap = 1'b0;
        conv = 1'b0;
    endtask

    task automatic s_lvl1;
        chk_val({3'h0, safety_level}, {3'h0, LVL_1});
        wr(1'b0, 1'b1, 3'h3);
        chk_val(wdt_rdata, 5'h08);
        wr(1'b0, 1'b0, 3'h0);
        chk_val(wdt_rdata, 5'h08);
        wr(1'b1, 1'b1, 3'h0);
        chk_val(wdt_rdata, 5'h18);
        repeat (3) @(negedge clk);
        chk_val(wdt_rdata, 5'h18);
        @(negedge clk);
        chk_val(wdt_rdata, 5'h08);
        wr(1'b0, 1'b0, 3'h5);
        chk_val(wdt_rdata, 5'h08);
        wr(1'b1, 1'b1, 3'h0);
        wr(1'b0, 1'b0, 3'h5);
        chk_val(wdt_rdata, 5'h05);
    endtask

    task automatic s_lvl0;
        chk_val({3'h0, safety_level}, {3'h0, LVL_0});
        chk_val(wdt_rdata, 5'h00);
        wr(1'b0, 1'b1, 3'h6);
        chk_val(wdt_rdata, 5'h0e);
        wr(1'b0, 1'b0, 3'h2);
        chk_val(wdt_rdata, 5'h0a);
        wr(1'b1, 1'b1, 3'h2);
        wr(1'b0, 1'b0, 3'h2);
        chk_val(wdt_rdata, 5'h02);
    endtask

    task automatic s_lvl2;
        chk_val({3'h0, safety_level}, {3'h0, LVL_2});
        chk_val(wdt_rdata, 5'h08);
        wr(1'b0, 1'b0, 3'h4);
        chk_val(wdt_rdata, 5'h08);
        wr(1'b1, 1'b1, 3'h0);
        wr(1'b0, 1'b0, 3'h3);
        chk_val(wdt_rdata, 5'h0b);
    endtask

    task automatic s_wdog;
        int n;
        wr(1'b0, 1'b1, 3'h0);
        wait_lvl(1'b1, 600, n);
        chk_rng(n, (BASE - 1) * 25 - 5, BASE * 25 + 20);
        wait_lvl(1'b0, 60, n);
        chk_rng(n, TOUT, TOUT + 6);
        chk_bit(wd_reset_flag, 1'b1);
        @(negedge clk);
        flag_wr = 1'b1;
        flag_wdata = 1'b0;
        @(negedge clk);
        flag_wr = 1'b0;
        chk_bit(wd_reset_flag, 1'b0);
        wr(1'b0, 1'b1, 3'h1);
        wait_lvl(1'b1, 1200, n);
        chk_rng(n, (2 * BASE - 1) * 25 - 5, 2 * BASE * 25 + 20);
        wait_lvl(1'b0, 60, n);
        chk_bit(wd_reset_flag, 1'b1);
        @(negedge clk);
        supply_low = 1'b1;
        repeat (5) @(negedge clk);
        supply_low = 1'b0;
        wait_lvl(1'b0, 60, n);
        chk_bit(wd_reset_flag, 1'b0);
        chk_val(wdt_rdata, 5'h00);
    endtask

    task automatic s_restart;
        wr(1'b0, 1'b1, 3'h0);
        repeat (5) begin
            repeat (300) @(negedge clk);
            chk_bit(core_reset, 1'b0);
            wd_restart = 1'b1;
            @(negedge clk);
            wd_restart = 1'b0;
        end
        wr(1'b1, 1'b1, 3'h0);
        wr(1'b0, 1'b0, 3'h0);
        repeat (500) @(negedge clk);
        chk_bit(core_reset, 1'b0);
        chk_bit(wd_reset_flag, 1'b0);
    endtask

    task automatic s_bod;
        int n;
        chk_bit(vref_enable, 1'b1);
        low_supply_detect = 1'b1;
        repeat (20) @(negedge clk);
        low_supply_detect = 1'b0;
        repeat (10) @(negedge clk);
        chk_bit(core_reset, 1'b0);
        low_supply_detect = 1'b1;
        wait_lvl(1'b1, 80, n);
        chk_rng(n, 48, 58);
        repeat (10) @(negedge clk);
        low_supply_detect = 1'b0;
        wait_lvl(1'b0, 60, n);
        chk_rng(n, TOUT, TOUT + 8);
    endtask

    initial begin
        n_mismatch = 0;
        checks = 0;
        tout = 16'(TOUT);
        rst = 1'b1;
        supply_low = 1'b0;
        reset_pin_n = 1'b1;
        low_supply_detect = 1'b0;
        fuses = 3'h0;
        wd_restart = 1'b0;
        wdt_wr = 1'b0;
        wdt_wdata = 5'h00;
        flag_wr = 1'b0;
        flag_wdata = 1'b1;
        bandgap = 1'b0;
        conv = 1'b0;
        do_reset(3'h0);
        s_supply();
        s_pin();
        s_vref();
        s_lvl1();
        do_reset(3'h2);
        s_lvl0();
        s_wdog();
        s_restart();
        do_reset(3'h4);
        s_lvl2();
        do_reset(3'h1);
        s_bod();
        close_out();
    end
endmodule

`default_nettype wire
